// ### uart_irq_regs.svh
// register offsets, field positions, reset values and timing counts of the serial interrupt block
// Operation
// - six sources can request: tx empty, tx idle, rx trigger, overrun, address, pin wake.
// - the combined request leaves the block as a one-cycle low pulse.
// - vectoring needs global enable, port enable and a non-full return stack.
// - four sources have flags; each tx source own enable, rx sources share one.
// - address detect has no flag but requests when address match is enabled.
// - with clock stopped and enables set, a falling serial pin edge requests wake.
// - flags are read-only, survive vectoring, clear only by the port's own accesses.
// - with address match on, rx-available requests only when top bit is one.
// - the top bit is the ninth with nine-bit select, else the eighth.
// - with address match off, every rx-available set requests.
// - a transmission pauses while the port clock is stopped and then resumes.
// - a reception pauses in place during idle or sleep.
// - idle or sleep leaves status, control, fifo, count, buffer and divisors alone.
// - serial data during the post-wake delay is ignored.
// - pin wake requests an interrupt only with global and port enables set.
// - the wake interrupt is held until the post-wake delay has ended.
// - the cpu-level port enable masks the combined request independently.
// - nine-bit select stores the received top bit in the ninth-bit field.
// - an overrun raises the shared receive request when the receive interrupt enable is set.
`ifndef UART_IRQ_REGS_SVH
`define UART_IRQ_REGS_SVH
// ==========================================
// register byte offsets
`define OFS_STATUS 12'h000
`define OFS_CTRL_ONE 12'h004
`define OFS_CTRL_TWO 12'h008
`define OFS_CPU_CTRL 12'h00c
`define OFS_RX_DATA 12'h010
// ==========================================
// control two fields
`define C2_TX_EMPTY_IE 0
`define C2_TX_IDLE_IE 1
`define C2_RX_IE 2
`define C2_ADDR_EN 3
`define C2_WAKE_EN 4
`define C2_NINE_BIT 5
`define C2_PORT_EN 6
`define C2_RX_EN 7
`define C2_PARITY_EN 8
// control one and cpu fields
`define C1_NINTH_BIT 0
`define CPU_GLOBAL_IE 0
`define CPU_PORT_IE 1
// status fields
`define ST_TX_EMPTY 0
`define ST_TX_IDLE 1
`define ST_RX_AVAIL 2
`define ST_OVERRUN 3
// reset values
`define RST_CTRL_TWO 9'h000
`define RST_CPU_CTRL 2'h0
// ==========================================
// timing
`define CLK_PERIOD_NS 8
`define WAKE_DELAY_NS 1024
`define WAKE_DELAY_CYC ((`WAKE_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// ### uart_irq_pkg.sv
// types shared by the serial interrupt block
package uart_irq_pkg;
	typedef enum logic [1:0] {
		WK_RUN = 2'b00,
		WK_STOPPED = 2'b01,
		WK_SETTLE = 2'b10
	} wake_state_t;
endpackage : uart_irq_pkg

// ### pin_sync.sv
// two-flop synchroniser for the serial pin
`timescale 1ns/1ps
module pin_sync (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_reset,
	// pin
	input wire logic i_pin,
	output logic o_pin
);
	logic meta_ff;
	logic sync_ff;

	// reset high matches an idle serial line
	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			meta_ff <= 1'b1;
			sync_ff <= 1'b1;
		end else begin
			meta_ff <= i_pin;
			sync_ff <= meta_ff;
		end
	end
	assign o_pin = sync_ff;
endmodule : pin_sync

// ### irq_pulse.sv
// turns a request level into a one-cycle low pulse on each rising edge
`timescale 1ns/1ps
module irq_pulse (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_reset,
	// request
	input wire logic i_req,
	output logic o_pulse_n
);
	logic req_ff;
	logic pulse_n_ff;

	// one low cycle per new request
	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			req_ff <= 1'b0;
			pulse_n_ff <= 1'b1;
		end else begin
			req_ff <= i_req;
			pulse_n_ff <= ~(i_req & ~req_ff);
		end
	end
	assign o_pulse_n = pulse_n_ff;
endmodule : irq_pulse

// ### uart_irq_addr_detect_wake.sv
// interrupt merge, address detect and pin wake logic of the serial port
//
// The register offsets and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/1ps
`include "uart_irq_regs.svh"
module uart_irq_addr_detect_wake
	import uart_irq_pkg::*;
#(
	parameter int WAKE_CYC = `WAKE_DELAY_CYC
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_reset,
	// axi4-lite write address and data
	input wire logic [11:0] i_awaddr,
	input wire logic i_awvalid,
	output logic o_awready,
	input wire logic [31:0] i_wdata,
	input wire logic [3:0] i_wstrb,
	input wire logic i_wvalid,
	output logic o_wready,
	// axi4-lite write response
	output logic [1:0] o_bresp,
	output logic o_bvalid,
	input wire logic i_bready,
	// axi4-lite read
	input wire logic [11:0] i_araddr,
	input wire logic i_arvalid,
	output logic o_arready,
	output logic [31:0] o_rdata,
	output logic [1:0] o_rresp,
	output logic o_rvalid,
	input wire logic i_rready,
	// serial core events and status
	input wire logic i_tx_empty,
	input wire logic i_tx_idle,
	input wire logic i_rx_word_done,
	input wire logic [8:0] i_rx_word,
	input wire logic i_rx_trigger,
	input wire logic i_overrun_evt,
	input wire logic i_tx_busy,
	input wire logic i_rx_busy,
	// clock and power state
	input wire logic i_port_clock_on,
	input wire logic i_stack_full,
	// serial pin
	input wire logic i_serial_pin,
	// outputs
	output logic o_irq_pulse_n,
	output logic o_vector_req,
	output logic o_wake,
	output logic o_tx_pause,
	output logic o_rx_pause,
	output logic o_rx_accept,
	output logic o_parity_enable
);
	// ==========================================
	// register state
	logic [8:0] ctrl2_ff;
	logic [1:0] cpu_ff;
	logic ninth_bit_ff;
	logic rx_avail_ff;
	logic overrun_ff;
	logic status_seen_ff;
	logic [8:0] rx_data_ff;
	logic addr_evt_ff;
	logic rx_evt_ff;
	logic pin_s;
	logic pin_prev_ff;
	wake_state_t wk_ff;
	wake_state_t nxt_wk;
	logic [15:0] wk_cnt_ff;
	logic wake_irq_ff;

	// ==========================================
	// bus handshake state
	logic aw_ff;
	logic w_ff;
	logic [11:0] awaddr_ff;
	logic [31:0] wdata_ff;
	logic [3:0] wstrb_ff;
	logic bvalid_ff;
	logic [1:0] bresp_ff;
	logic rvalid_ff;
	logic [31:0] rdata_ff;
	logic [1:0] rresp_ff;

	// decode of a register offset
	function automatic logic mapped(input logic [11:0] a);
		mapped = (a == `OFS_STATUS) || (a == `OFS_CTRL_ONE) || (a == `OFS_CTRL_TWO) ||
			(a == `OFS_CPU_CTRL) || (a == `OFS_RX_DATA);
	endfunction : mapped

	pin_sync u_pin_sync (
		.i_clk(i_clk),
		.i_reset(i_reset),
		.i_pin(i_serial_pin),
		.o_pin(pin_s)
	);

	// ==========================================
	// named control fields
	wire tx_empty_ie = ctrl2_ff[`C2_TX_EMPTY_IE];
	wire tx_idle_ie = ctrl2_ff[`C2_TX_IDLE_IE];
	wire rx_ie = ctrl2_ff[`C2_RX_IE];
	wire addr_en = ctrl2_ff[`C2_ADDR_EN];
	wire wake_en = ctrl2_ff[`C2_WAKE_EN];
	wire nine_bit = ctrl2_ff[`C2_NINE_BIT];
	wire port_en = ctrl2_ff[`C2_PORT_EN];
	wire rx_en = ctrl2_ff[`C2_RX_EN];
	wire global_ie = cpu_ff[`CPU_GLOBAL_IE];
	wire port_ie = cpu_ff[`CPU_PORT_IE];

	// bus transfer strobes
	wire wr_go = aw_ff & w_ff & ~bvalid_ff;
	wire rd_go = i_arvalid & ~rvalid_ff;
	wire wr_ok = wr_go & mapped(awaddr_ff);
	wire wr_ctrl2 = wr_ok & (awaddr_ff == `OFS_CTRL_TWO);
	wire wr_cpu = wr_ok & (awaddr_ff == `OFS_CPU_CTRL);
	wire rd_status = rd_go & (i_araddr == `OFS_STATUS);
	wire rd_data = rd_go & (i_araddr == `OFS_RX_DATA);
	// flags clear by a status access followed by a data read
	wire flag_clear = rd_data & status_seen_ff;

	// ==========================================
	// receive qualification
	wire running = (wk_ff == WK_RUN);
	wire word_in = i_rx_word_done & running;
	wire top_bit = nine_bit ? i_rx_word[8] : i_rx_word[7];
	wire rx_qual = ~addr_en | top_bit;

	// ==========================================
	// sources merged before the cpu mask
	wire src_tx_empty = tx_empty_ie & i_tx_empty;
	wire src_tx_idle = tx_idle_ie & i_tx_idle;
	wire src_rx = rx_ie & (rx_evt_ff | overrun_ff);
	wire src_addr = addr_en & addr_evt_ff;
	wire comb_req = src_tx_empty | src_tx_idle | src_rx | src_addr | wake_irq_ff;
	wire masked_req = comb_req & global_ie & port_ie & running;

	irq_pulse u_irq_pulse (
		.i_clk(i_clk),
		.i_reset(i_reset),
		.i_req(masked_req),
		.o_pulse_n(o_irq_pulse_n)
	);

	// vector only with both enables and room on the return stack
	assign o_vector_req = masked_req & ~i_stack_full;

	// ==========================================
	// power and wake
	wire wake_arm = port_en & rx_en & wake_en & rx_ie;
	wire fall = pin_prev_ff & ~pin_s;
	assign o_tx_pause = ~i_port_clock_on & i_tx_busy;
	assign o_rx_pause = ~i_port_clock_on & i_rx_busy;
	assign o_wake = (wk_ff == WK_STOPPED) & wake_arm & fall;
	assign o_rx_accept = running;
	assign o_parity_enable = ctrl2_ff[`C2_PARITY_EN] & ~addr_en;

	// wake state choice
	always_comb begin
		nxt_wk = wk_ff;
		case (wk_ff)
			WK_RUN: begin
				if (!i_port_clock_on) begin
					nxt_wk = WK_STOPPED;
				end
			end
			WK_STOPPED: begin
				if (o_wake || i_port_clock_on) begin
					nxt_wk = WK_SETTLE;
				end
			end
			WK_SETTLE: begin
				if (wk_cnt_ff >= 16'(WAKE_CYC - 1)) begin
					nxt_wk = WK_RUN;
				end
			end
			default: begin
				nxt_wk = WK_RUN;
			end
		endcase
	end

	// wake sequencer and delay count
	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			wk_ff <= WK_RUN;
			wk_cnt_ff <= 16'h0000;
			pin_prev_ff <= 1'b1;
			wake_irq_ff <= 1'b0;
		end else begin
			wk_ff <= nxt_wk;
			pin_prev_ff <= pin_s;
			wk_cnt_ff <= (wk_ff == WK_SETTLE) ? wk_cnt_ff + 16'h0001 : 16'h0000;
			if (o_wake) begin
				wake_irq_ff <= 1'b1;
			end else if (running) begin
				wake_irq_ff <= 1'b0;
			end
		end
	end

	// status flags: set wins over clear; idle keeps all state
	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			rx_avail_ff <= 1'b0;
			overrun_ff <= 1'b0;
			status_seen_ff <= 1'b0;
			rx_data_ff <= 9'h000;
			ninth_bit_ff <= 1'b0;
			rx_evt_ff <= 1'b0;
			addr_evt_ff <= 1'b0;
		end else begin
			if (rd_status) begin
				status_seen_ff <= 1'b1;
			end else if (rd_data) begin
				status_seen_ff <= 1'b0;
			end
			rx_avail_ff <= word_in | (rx_avail_ff & ~flag_clear);
			overrun_ff <= (i_overrun_evt & running) | (overrun_ff & ~flag_clear);
			rx_evt_ff <= i_rx_trigger & running & rx_qual;
			addr_evt_ff <= word_in & addr_en & top_bit;
			if (word_in) begin
				rx_data_ff <= i_rx_word;
				ninth_bit_ff <= nine_bit ? i_rx_word[8] : 1'b0;
			end
		end
	end

	// control registers written by software only
	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			ctrl2_ff <= `RST_CTRL_TWO;
			cpu_ff <= `RST_CPU_CTRL;
		end else begin
			if (wr_ctrl2 && wstrb_ff[0]) begin
				ctrl2_ff[7:0] <= wdata_ff[7:0];
			end
			if (wr_ctrl2 && wstrb_ff[1]) begin
				ctrl2_ff[8] <= wdata_ff[8];
			end
			if (wr_cpu && wstrb_ff[0]) begin
				cpu_ff <= wdata_ff[1:0];
			end
		end
	end

	// ==========================================
	// axi4-lite slave
	assign o_awready = ~aw_ff;
	assign o_wready = ~w_ff;
	assign o_arready = ~rvalid_ff;
	assign o_bvalid = bvalid_ff;
	assign o_bresp = bresp_ff;
	assign o_rvalid = rvalid_ff;
	assign o_rdata = rdata_ff;
	assign o_rresp = rresp_ff;

	wire [31:0] status_word = {28'h0000000, overrun_ff, rx_avail_ff, i_tx_idle, i_tx_empty};
	wire [31:0] rd_word =
		(i_araddr == `OFS_STATUS) ? status_word :
		(i_araddr == `OFS_CTRL_ONE) ? {31'h00000000, ninth_bit_ff} :
		(i_araddr == `OFS_CTRL_TWO) ? {23'h000000, ctrl2_ff} :
		(i_araddr == `OFS_CPU_CTRL) ? {30'h00000000, cpu_ff} :
		(i_araddr == `OFS_RX_DATA) ? {23'h000000, rx_data_ff} : 32'h00000000;

	// write channel capture and response
	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			aw_ff <= 1'b0;
			w_ff <= 1'b0;
			awaddr_ff <= 12'h000;
			wdata_ff <= 32'h00000000;
			wstrb_ff <= 4'h0;
			bvalid_ff <= 1'b0;
			bresp_ff <= `RESP_OKAY;
		end else begin
			if (i_awvalid && !aw_ff) begin
				aw_ff <= 1'b1;
				awaddr_ff <= i_awaddr;
			end
			if (i_wvalid && !w_ff) begin
				w_ff <= 1'b1;
				wdata_ff <= i_wdata;
				wstrb_ff <= i_wstrb;
			end
			if (wr_go) begin
				aw_ff <= 1'b0;
				w_ff <= 1'b0;
				bvalid_ff <= 1'b1;
				bresp_ff <= mapped(awaddr_ff) ? `RESP_OKAY : `RESP_SLVERR;
			end else if (bvalid_ff && i_bready) begin
				bvalid_ff <= 1'b0;
			end
		end
	end

	// read channel
	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			rvalid_ff <= 1'b0;
			rdata_ff <= 32'h00000000;
			rresp_ff <= `RESP_OKAY;
		end else begin
			if (rd_go) begin
				rvalid_ff <= 1'b1;
				rdata_ff <= rd_word;
				rresp_ff <= mapped(i_araddr) ? `RESP_OKAY : `RESP_SLVERR;
			end else if (rvalid_ff && i_rready) begin
				rvalid_ff <= 1'b0;
			end
		end
	end

	// ==========================================
	// checks
	AST_PULSE_ONE: assert property (@(posedge i_clk) disable iff (i_reset)
		!o_irq_pulse_n |=> o_irq_pulse_n)
		else $error("interrupt pulse longer than one cycle");
	AST_PULSE_CAUSE: assert property (@(posedge i_clk) disable iff (i_reset)
		$rose(masked_req) |=> !o_irq_pulse_n)
		else $error("request rise gave no pulse");
	AST_VECTOR: assert property (@(posedge i_clk) disable iff (i_reset)
		o_vector_req |-> global_ie && port_ie && !i_stack_full)
		else $error("vector without enables");
	AST_ADDR_QUAL: assert property (@(posedge i_clk) disable iff (i_reset)
		(i_rx_trigger && running && addr_en && !top_bit) |=> !rx_evt_ff)
		else $error("data word passed address filter");
	AST_NOADDR: assert property (@(posedge i_clk) disable iff (i_reset)
		(i_rx_trigger && running && !addr_en) |=> rx_evt_ff)
		else $error("rx event lost without address mode");
	AST_OVERRUN: assert property (@(posedge i_clk) disable iff (i_reset)
		(i_overrun_evt && running && rx_ie) |=> comb_req)
		else $error("overrun raised no request");
	AST_FLAG_HOLD: assert property (@(posedge i_clk) disable iff (i_reset)
		(rx_avail_ff && !flag_clear) |=> rx_avail_ff)
		else $error("flag cleared without access");
	AST_WAKE_HOLD: assert property (@(posedge i_clk) disable iff (i_reset)
		o_wake |=> !masked_req [*2])
		else $error("wake request before delay");
	AST_IGNORE: assert property (@(posedge i_clk) disable iff (i_reset)
		(i_rx_word_done && !running && !rx_avail_ff) |=> !rx_avail_ff)
		else $error("data taken during wake delay");
	AST_NINTH: assert property (@(posedge i_clk) disable iff (i_reset)
		(word_in && nine_bit) |=> ninth_bit_ff == $past(i_rx_word[8]))
		else $error("ninth bit not stored");
endmodule : uart_irq_addr_detect_wake

// ### serial_partner.sv
// remote serial transmitter model driving the shared serial line
`timescale 1ns/1ps
module serial_partner (
	// serial line, driven high by this model while idle
	output logic o_line
);
	// ==========================================
	// line idles high between frames
	initial begin
		o_line = 1'b1;
	end
	// one frame: start bit, eight data bits lsb first, stop bit
	task automatic send_byte(input logic [7:0] d, input int bit_ns);
		o_line = 1'b0; // start bit gives the falling edge
		#(bit_ns);
		for (int i = 0; i < 8; i++) begin
			o_line = d[i];
			#(bit_ns);
		end
		o_line = 1'b1; // driven back high to the idle line level
		#(bit_ns);
	endtask : send_byte
endmodule : serial_partner

// ### test_uart_irq_addr_detect_wake.sv
// self-checking bench of the serial interrupt, address detect and wake block
`timescale 1ns/1ps
`include "uart_irq_regs.svh"
module test_uart_irq_addr_detect_wake;
	import uart_irq_pkg::*;
	// ==========================================
	// stimulus and observation signals
	localparam int WK = 4;
	localparam logic [31:0] TXE = 32'h1 << `C2_TX_EMPTY_IE;
	localparam logic [31:0] TXI = 32'h1 << `C2_TX_IDLE_IE;
	localparam logic [31:0] RXI = 32'h1 << `C2_RX_IE;
	localparam logic [31:0] ADR = 32'h1 << `C2_ADDR_EN;
	localparam logic [31:0] WKE = 32'h1 << `C2_WAKE_EN;
	localparam logic [31:0] NIN = 32'h1 << `C2_NINE_BIT;
	localparam logic [31:0] PEN = 32'h1 << `C2_PORT_EN;
	localparam logic [31:0] RXE = 32'h1 << `C2_RX_EN;
	localparam logic [31:0] PAR = 32'h1 << `C2_PARITY_EN;
	logic i_clk = 1'b0;
	logic i_reset;
	logic [11:0] awaddr, araddr;
	logic [31:0] wdata;
	logic [3:0] wstrb;
	logic awvalid, wvalid, bready, arvalid, rready;
	logic tx_empty, tx_idle, rx_word_done, rx_trigger, overrun_evt;
	logic tx_busy, rx_busy, port_clock_on, stack_full;
	logic [8:0] rx_word;
	wire serial_pin;
	wire awready, wready, bvalid, arready, rvalid;
	wire [1:0] bresp, rresp;
	wire [31:0] rdata;
	wire irq_n, vector_req, wake, tx_pause, rx_pause, rx_accept, parity_en;
	logic [34:0] exp_q[$];
	logic [34:0] ent;
	logic irq_prev = 1'b1;
	int n_mismatch = 0;
	int cmp_count = 0;
	int irq_edges = 0;
	int irq_low = 0;
	int wake_seen = 0;
	int seed;
	int base;
	int wk0;
	int t;
	// ==========================================
	// clock, design and far-side transmitter
	always #4 i_clk = ~i_clk;
	serial_partner partner (.o_line(serial_pin));
	uart_irq_addr_detect_wake #(.WAKE_CYC(WK)) uut (
		.i_clk(i_clk), .i_reset(i_reset),
		.i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready),
		.i_wdata(wdata), .i_wstrb(wstrb), .i_wvalid(wvalid), .o_wready(wready),
		.o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready),
		.i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready),
		.o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready),
		.i_tx_empty(tx_empty), .i_tx_idle(tx_idle), .i_rx_word_done(rx_word_done),
		.i_rx_word(rx_word), .i_rx_trigger(rx_trigger), .i_overrun_evt(overrun_evt),
		.i_tx_busy(tx_busy), .i_rx_busy(rx_busy), .i_port_clock_on(port_clock_on),
		.i_stack_full(stack_full), .i_serial_pin(serial_pin),
		.o_irq_pulse_n(irq_n), .o_vector_req(vector_req), .o_wake(wake),
		.o_tx_pause(tx_pause), .o_rx_pause(rx_pause), .o_rx_accept(rx_accept),
		.o_parity_enable(parity_en)
	);
	// ==========================================
	// comparison, verdict and bus tasks
	task check(input string name, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			$display("mismatch %s expected %h seen %h", name, exp, got);
			n_mismatch++;
		end
	endtask : check
	task complete_run;
		$display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : complete_run
	// write with address and data offered together, response noted in the queue
	task wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
		logic ah, wh, ad, wd, bh;
		ad = 1'b0;
		wd = 1'b0;
		bh = 1'b0;
		exp_q.push_back({1'b0, r, 32'h0});
		@(posedge i_clk);
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hf;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(ad && wd)) begin
			@(negedge i_clk);
			ah = awready;
			wh = wready;
			@(posedge i_clk);
			if (ah && !ad) begin
				awvalid <= 1'b0;
				ad = 1'b1;
			end
			if (wh && !wd) begin
				wvalid <= 1'b0;
				wd = 1'b1;
			end
		end
		while (!bh) begin
			@(negedge i_clk);
			bh = bvalid;
			@(posedge i_clk);
		end
		bready <= 1'b0;
	endtask : wr
	// read whose expected response and data go into the queue
	task rd(input logic [11:0] a, input logic [31:0] d, input logic c, input logic [1:0] r);
		logic ah, rh;
		ah = 1'b0;
		rh = 1'b0;
		exp_q.push_back({c, r, d});
		@(posedge i_clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (!ah) begin
			@(negedge i_clk);
			ah = arready;
			@(posedge i_clk);
		end
		arvalid <= 1'b0;
		while (!rh) begin
			@(negedge i_clk);
			rh = rvalid;
			@(posedge i_clk);
		end
		rready <= 1'b0;
	endtask : rd
	// pulses counted since a snapshot, after the fixed request latency
	task irq_since(input int b, input int n);
		repeat (6) @(posedge i_clk);
		check("irq pulses", n, irq_edges - b);
	endtask : irq_since
	// ==========================================
	// watcher: takes the oldest note at each bus answer, counts pulses
	always @(negedge i_clk) begin
		if ((rvalid && rready) || (bvalid && bready)) begin
			ent = exp_q.pop_front();
			check("resp", {30'h0, ent[33:32]}, {30'h0, rvalid ? rresp : bresp});
			if (ent[34] && rvalid) begin
				check("rdata", ent[31:0], rdata);
			end
		end
		if (!irq_n && irq_prev) begin
			irq_edges++;
		end
		if (!irq_n) begin
			irq_low++;
		end
		irq_prev = irq_n;
		if (wake) begin
			wake_seen++;
		end
	end
	// watchdog well beyond the expected run length
	initial begin
		#200000;
		n_mismatch++;
		complete_run();
	end
	// ==========================================
	// main sequence
	initial begin
		seed = 94;
		{awaddr, araddr, wdata, wstrb, awvalid, wvalid, bready, arvalid, rready} = '0;
		{tx_empty, tx_idle, rx_word_done, rx_trigger, overrun_evt, rx_word} = '0;
		{tx_busy, rx_busy, stack_full} = '0;
		port_clock_on = 1'b1;
		i_reset = 1'b1;
		repeat (3) @(posedge i_clk);
		i_reset <= 1'b0;
		// reset values and an unmapped place
		rd(`OFS_CTRL_TWO, 32'h0, 1'b1, `RESP_OKAY);
		rd(`OFS_CPU_CTRL, 32'h0, 1'b1, `RESP_OKAY);
		rd(`OFS_STATUS, 32'h0, 1'b1, `RESP_OKAY);
		rd(12'h020, 32'h0, 1'b1, `RESP_SLVERR);
		wr(12'h020, 32'h5, `RESP_SLVERR);
		// tx empty source, flag kept after vectoring, stack full blocks vectoring
		wr(`OFS_CPU_CTRL, 32'h3, `RESP_OKAY);
		wr(`OFS_CTRL_TWO, TXE, `RESP_OKAY);
		base = irq_edges;
		tx_empty <= 1'b1;
		irq_since(base, 1);
		rd(`OFS_STATUS, 32'h1, 1'b1, `RESP_OKAY);
		check("vector", 1, vector_req);
		stack_full <= 1'b1;
		@(negedge i_clk);
		check("vector full", 0, vector_req);
		@(posedge i_clk);
		stack_full <= 1'b0;
		tx_empty <= 1'b0;
		// cpu-level mask holds back then passes the tx idle request
		wr(`OFS_CPU_CTRL, 32'h1, `RESP_OKAY);
		wr(`OFS_CTRL_TWO, TXI, `RESP_OKAY);
		base = irq_edges;
		tx_idle <= 1'b1;
		irq_since(base, 0);
		wr(`OFS_CPU_CTRL, 32'h3, `RESP_OKAY);
		irq_since(base, 1);
		tx_idle <= 1'b0;
		// address qualifier over both word lengths and both top bits
		for (int i = 0; i < 8; i++) begin
			wr(`OFS_CTRL_TWO, RXI | RXE | (i[2] ? ADR : 0) | (i[1] ? NIN : 0), `RESP_OKAY);
			base = irq_edges;
			@(posedge i_clk);
			rx_word <= {i[0], ~i[0], 7'($random(seed))};
			rx_word_done <= 1'b1;
			rx_trigger <= 1'b1;
			@(posedge i_clk);
			rx_word_done <= 1'b0;
			rx_trigger <= 1'b0;
			irq_since(base, (!i[2] || (i[1] ? i[0] : !i[0])) ? 1 : 0);
			rd(`OFS_STATUS, 32'h4, 1'b1, `RESP_OKAY);
			rd(`OFS_CTRL_ONE, {31'h0, i[1] & i[0]}, 1'b1, `RESP_OKAY);
			rd(`OFS_RX_DATA, {23'h0, rx_word}, 1'b1, `RESP_OKAY);
		end
		// parity passes through while address mode is off
		wr(`OFS_CTRL_TWO, PAR, `RESP_OKAY);
		check("parity", 1, parity_en);
		// software drops parity in the same write that turns address mode on
		wr(`OFS_CTRL_TWO, ADR, `RESP_OKAY);
		check("parity addr", 0, parity_en);
		// overrun raises the shared receive request, cleared by status then data
		wr(`OFS_CTRL_TWO, RXI, `RESP_OKAY);
		base = irq_edges;
		overrun_evt <= 1'b1;
		@(posedge i_clk);
		overrun_evt <= 1'b0;
		irq_since(base, 1);
		rd(`OFS_STATUS, 32'h8, 1'b1, `RESP_OKAY);
		rd(`OFS_RX_DATA, {23'h0, rx_word}, 1'b1, `RESP_OKAY);
		rd(`OFS_STATUS, 32'h0, 1'b1, `RESP_OKAY);
		// transfers pause while the port clock is off, registers kept
		tx_busy <= 1'b1;
		rx_busy <= 1'b1;
		port_clock_on <= 1'b0;
		repeat (2) @(negedge i_clk);
		check("tx pause", 1, tx_pause);
		check("rx pause", 1, rx_pause);
		rd(`OFS_CTRL_TWO, RXI, 1'b1, `RESP_OKAY);
		port_clock_on <= 1'b1;
		@(negedge i_clk);
		check("tx resume", 0, tx_pause);
		check("rx resume", 0, rx_pause);
		@(posedge i_clk);
		{tx_busy, rx_busy} <= 2'b00;
		// pin wake with and without the cpu enables
		for (int k = 0; k < 2; k++) begin
			wr(`OFS_CPU_CTRL, k ? 32'h0 : 32'h3, `RESP_OKAY);
			wr(`OFS_CTRL_TWO, PEN | RXE | WKE | RXI, `RESP_OKAY);
			port_clock_on <= 1'b0; // transfers already finished
			repeat (3) @(posedge i_clk);
			base = irq_edges;
			wk0 = wake_seen;
			fork
				partner.send_byte(8'($random(seed)), 80);
			join_none
			for (t = 0; t < 200 && wake_seen == wk0; t++) @(posedge i_clk);
			check("wake", 1, wake_seen - wk0);
			port_clock_on <= 1'b1;
			@(negedge i_clk);
			check("accept settle", 0, rx_accept);
			check("held irq", 0, irq_edges - base);
			// a word finished inside the settle time must be dropped
			@(posedge i_clk);
			rx_word_done <= 1'b1;
			@(posedge i_clk);
			rx_word_done <= 1'b0;
			repeat (WK - 2) @(posedge i_clk);
			irq_since(base, k ? 0 : 1);
			check("accept run", 1, rx_accept);
			rd(`OFS_STATUS, 32'h0, 1'b1, `RESP_OKAY);
			#1000;
		end
		check("pulse width", irq_edges, irq_low);
		complete_run();
	end
endmodule : test_uart_irq_addr_detect_wake
